/* dv/dsp_eng_model.sv */
// Bench model of the engine that feeds access records
`default_nettype none
module dsp_eng_model
  import dsp_pkg::*;
(
  // Clock, reset and bench request
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 go_i,
  input  wire dsp_pkg::dsp_access_t rec_i,
  // Record stream towards the block
  input  wire logic                 ready_i,
  output logic                      valid_o,
  output dsp_pkg::dsp_access_t      acc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Hold until taken, then scramble so a stale record is never mistaken
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      acc_o   <= '0;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      acc_o   <= ~acc_o;
    end else if (go_i && !valid_o) begin
      valid_o <= 1'b1;
      acc_o   <= rec_i;
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the access status and pattern block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsp_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, go, av, ar, ce;
  logic [3:0]  sel;
  logic [7:0]  adr, match, seen, pat;
  logic [31:0] wdat, dat_o, rd, r32;
  dsp_access_t rec, acc, r;
  int          errors, n_compared, seed, c;

  dsp_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack),
    .acc_valid_i(av), .acc_ready_o(ar), .acc_i(acc), .match_end_o(match));
  dsp_eng_model eng (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .rec_i(rec), .ready_i(ar),
    .valid_o(av), .acc_o(acc));

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (i == 40) begin
      errors++;
      finish_test();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // Hand one record to the engine model and gather match pulses
  task automatic send(input dsp_access_t x);
    go  <= 1'b1;
    rec <= x;
    seen = 8'h00;
    repeat (12) begin
      @(posedge clk_i);
      go <= 1'b0;
      seen |= match;
    end
  endtask

  // Status and address must both describe the latest record
  task automatic chk_last(input dsp_access_t x);
    wb(1'b0, DSP_STATUS_OFS, 32'h0);
    chk("status", {28'h0, x.dir_rd, x.chan}, rd);
    wb(1'b0, DSP_ADDR_OFS, 32'h0);
    chk("address", x.addr, rd);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    seed = 73321;
    errors = 0;
    n_compared = 0;
    rst_i = 1'b1;
    ce = 1'b1;
    sel = 4'hf;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    go = 1'b0;
    rec = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, DSP_STATUS_OFS, 32'h0);
    chk("status_rst", 32'h0, rd);
    wb(1'b0, DSP_ADDR_OFS, 32'h0);
    chk("addr_rst", DSP_ADDR_RST, rd);
    // Every channel: terminate on match, then ignored with mode off
    for (c = 0; c < 8; c++) begin
      r32 = $random(seed);
      pat = r32[7:0];
      wb(1'b1, DSP_PAT_BASE + 8'(4 * c), r32);
      wb(1'b0, DSP_PAT_BASE + 8'(4 * c), 32'h0);
      chk("pattern", {24'h0, pat}, rd);
      wb(1'b1, DSP_MODE_OFS, 32'h1 << c);
      r = 44'({$random(seed), $random(seed)});
      r.chan = 3'(c);
      r.data = pat ^ 8'h5a;
      send(r);
      chk("miss", 32'h0, {24'h0, seen});
      r.data = pat;
      send(r);
      chk("match", 32'h1 << c, {24'h0, seen});
      chk_last(r);
      wb(1'b1, DSP_MODE_OFS, 32'h0);
      r.dir_rd = ~r.dir_rd;
      r.addr = $random(seed);
      send(r);
      chk("ignored", 32'h0, {24'h0, seen});
      chk_last(r);
    end
    // Frozen clock enable: the record waits at the port, then lands
    ce <= 1'b0;
    r.addr = $random(seed);
    send(r);
    chk("ready_frozen", 32'h0, {31'h0, ar});
    ce <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk_last(r);
    // Pattern write without byte lane 0 keeps the old pattern
    sel <= 4'he;
    wb(1'b1, DSP_PAT_BASE + 8'h1c, ~{24'h0, pat});
    sel <= 4'hf;
    wb(1'b0, DSP_PAT_BASE + 8'h1c, 32'h0);
    chk("pat_lane", {24'h0, pat}, rd);
    // Read-only status survives a write; unmapped reads zero
    wb(1'b1, DSP_STATUS_OFS, 32'hffff_ffff);
    wb(1'b1, DSP_ADDR_OFS, 32'hffff_ffff);
    chk_last(r);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    finish_test();
  end
endmodule
`default_nettype wire

/* rtl/dsp_core.sv */
// DMA last-access status, address capture and per-channel pattern match
`default_nettype none
module dsp_core
  import dsp_pkg::*;
#(
  parameter int NCH   = dsp_pkg::DSP_NCH,
  parameter int DEPTH = dsp_pkg::DSP_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // Wishbone classic slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic [31:0]              dat_o,
  output logic                     ack_o,
  // Access records from the engine
  input  wire logic                acc_valid_i,
  output logic                     acc_ready_o,
  input  wire dsp_pkg::dsp_access_t acc_i,
  // Per-channel transfer end on pattern match, one-cycle pulse
  output logic [NCH-1:0]           match_end_o
);
  import dsp_pkg::*;

  localparam int CW = $bits(dsp_access_t);

  // Register state
  logic                 dir_reg, dir_next;
  logic [DSP_CH_W-1:0]  ch_reg, ch_next;
  logic [31:0]          addr_reg, addr_next;
  logic [NCH-1:0]       mode_reg, mode_next;
  logic [DSP_PAT_W-1:0] pat_reg [NCH];
  logic [DSP_PAT_W-1:0] pat_next [NCH];
  logic [NCH-1:0]       end_reg, end_next;
  // Bus slave state
  dsp_bus_state_t       st_reg, st_next;
  logic [31:0]          rd_reg, rd_next;
  // FIFO drain side
  logic                 f_valid;
  logic                 f_ready;
  logic [CW-1:0]        f_data;
  dsp_access_t          cur;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Pattern register index for an address, NCH when none
  function automatic int pat_index(input logic [7:0] a);
    int r;
    r = NCH;
    for (int c = 0; c < NCH; c++) begin
      if (a == DSP_PAT_BASE + 8'(c * 4)) begin
        r = c;
      end
    end
    return r;
  endfunction

  // Records queue here so engine bursts stall on the status logic only once DEPTH records are waiting
  dsp_fifo #(
    .W (CW),
    .D (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (acc_valid_i),
    .in_ready_o  (acc_ready_o),
    .in_data_i   (acc_i),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  // Drain stalls while a bus access is being answered, so the FIFO can fill
  assign f_ready = (st_reg == DSP_IDLE);
  assign cur     = dsp_access_t'(f_data);

  // Status capture and match detection
  always_comb begin
    dir_next  = dir_reg;
    ch_next   = ch_reg;
    addr_next = addr_reg;
    end_next  = '0;
    if (f_valid && f_ready) begin
      dir_next  = cur.dir_rd;
      ch_next   = cur.chan;
      addr_next = cur.addr;
      // Only channels in pattern mode compare
      if (int'(cur.chan) < NCH && mode_reg[cur.chan] &&
          cur.data == pat_reg[cur.chan]) begin
        end_next[cur.chan] = 1'b1;
      end
    end
  end

  // Bus slave: one wait state, ack pulse, ack drops the next cycle
  always_comb begin
    int pi;
    pi        = pat_index(adr_i);
    st_next   = st_reg;
    rd_next   = rd_reg;
    mode_next = mode_reg;
    for (int c = 0; c < NCH; c++) begin
      pat_next[c] = pat_reg[c];
    end
    case (st_reg)
      DSP_IDLE: begin
        if (cyc_i && stb_i) begin
          st_next = DSP_ACK;
          rd_next = 32'h0000_0000;
          if (we_i) begin
            if (adr_i == DSP_MODE_OFS) begin
              mode_next = NCH'(lane_merge(32'(mode_reg), dat_i, sel_i));
            end else if (pi < NCH && sel_i[0]) begin
              pat_next[pi] = dat_i[DSP_PAT_W-1:0];
            end
          end else if (adr_i == DSP_STATUS_OFS) begin
            rd_next[DSP_DIR_BIT] = dir_reg;
            rd_next[DSP_CH_LSB +: DSP_CH_W] = ch_reg;
          end else if (adr_i == DSP_ADDR_OFS) begin
            rd_next = addr_reg;
          end else if (adr_i == DSP_MODE_OFS) begin
            rd_next = 32'(mode_reg);
          end else if (pi < NCH) begin
            rd_next[DSP_PAT_W-1:0] = pat_reg[pi];
          end
        end
      end
      DSP_ACK: begin
        st_next = DSP_IDLE;
      end
      default: begin
        st_next = DSP_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_reg  <= 1'b0;
      ch_reg   <= '0;
      addr_reg <= DSP_ADDR_RST;
      mode_reg <= '0;
      end_reg  <= '0;
      st_reg   <= DSP_IDLE;
      rd_reg   <= 32'h0000_0000;
      for (int c = 0; c < NCH; c++) begin
        pat_reg[c] <= DSP_PAT_RST;
      end
    end else if (ce_i) begin
      dir_reg  <= dir_next;
      ch_reg   <= ch_next;
      addr_reg <= addr_next;
      mode_reg <= mode_next;
      end_reg  <= end_next;
      st_reg   <= st_next;
      rd_reg   <= rd_next;
      for (int c = 0; c < NCH; c++) begin
        pat_reg[c] <= pat_next[c];
      end
    end
  end

  // Ack waits for an enabled edge so a frozen slave never answers twice
  assign ack_o       = (st_reg == DSP_ACK) && ce_i;
  assign dat_o       = rd_reg;
  assign match_end_o = end_reg;

  // Check helpers: a bus request taken, a record drained
  logic chk_take;
  logic chk_drain;
  assign chk_take  = ce_i && (st_reg == DSP_IDLE) && cyc_i && stb_i;
  assign chk_drain = ce_i && f_valid && f_ready;

  // Capture checks
  a_dir_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && f_valid && f_ready |=> dir_reg == $past(cur.dir_rd))
    else $error("direction flag not captured");
  a_chan_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && f_valid && f_ready |=> ch_reg == $past(cur.chan))
    else $error("channel field not captured");
  a_addr_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && f_valid && f_ready |=> addr_reg == $past(cur.addr))
    else $error("address not captured");
  a_match_end: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && f_valid && f_ready && mode_reg[cur.chan] && cur.data == pat_reg[cur.chan]
    |=> match_end_o[$past(cur.chan)])
    else $error("pattern match did not end transfer");
  a_no_mode_end: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && f_valid && f_ready && !mode_reg[cur.chan] |=> match_end_o == '0)
    else $error("end raised outside pattern mode");
  a_status_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(adr_i) == DSP_STATUS_OFS && !$past(we_i) |-> dat_o[31:4] == '0)
    else $error("status upper bits not zero");
  a_pat_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(adr_i) >= DSP_PAT_BASE && !$past(we_i) |-> dat_o[31:8] == '0)
    else $error("pattern upper bits not zero");
  a_held_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !(f_valid && f_ready) && ce_i |=> $stable(addr_reg) && $stable(ch_reg) && $stable(dir_reg))
    else $error("status changed without access");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");

  // Bus checks: one answer per request, read data stands until the next one
  a_take_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    chk_take |=> st_reg == DSP_ACK)
    else $error("bus request not answered");
  a_no_stray_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !chk_take |=> !ack_o)
    else $error("ack without a request");
  a_ack_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |-> !ack_o)
    else $error("ack while disabled");
  a_rd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !chk_take |=> $stable(dat_o))
    else $error("read data moved without a request");
  a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(ce_i) && $past(adr_i) == DSP_STATUS_OFS && !$past(we_i)
    |-> dat_o[DSP_DIR_BIT] == $past(dir_reg) &&
        dat_o[DSP_CH_LSB +: DSP_CH_W] == $past(ch_reg))
    else $error("status read differs from capture");
  a_addr_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(ce_i) && $past(adr_i) == DSP_ADDR_OFS && !$past(we_i)
    |-> dat_o == $past(addr_reg))
    else $error("address read differs from capture");
  a_addr_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    chk_take && we_i && !chk_drain |=> $stable(addr_reg))
    else $error("address capture written by software");
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && !$past(we_i) && $past(adr_i) > DSP_PAT_BASE + 8'(4 * NCH - 4)
    |-> dat_o == '0)
    else $error("unmapped read not zero");

  // Pattern and mode checks
  a_pat_write: assert property (@(posedge clk_i) disable iff (rst_i)
    chk_take && we_i && adr_i == DSP_PAT_BASE && sel_i[0]
    |=> pat_reg[0] == $past(dat_i[DSP_PAT_W-1:0]))
    else $error("pattern write lost");
  a_pat_lane: assert property (@(posedge clk_i) disable iff (rst_i)
    chk_take && we_i && !sel_i[0] |=> pat_reg[0] == $past(pat_reg[0]))
    else $error("pattern written without its byte lane");
  a_mode_write: assert property (@(posedge clk_i) disable iff (rst_i)
    chk_take && we_i && adr_i == DSP_MODE_OFS && sel_i[0]
    |=> mode_reg[0] == $past(dat_i[0]))
    else $error("mode write lost");
  a_mode_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(chk_take && we_i) |=> $stable(mode_reg))
    else $error("mode changed without a write");
  a_end_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(match_end_o))
    else $error("more than one channel ended");
  a_end_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !chk_drain |=> match_end_o == '0)
    else $error("end pulse without a record");

  // Clock enable and stream checks
  a_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(st_reg) && $stable(addr_reg) && $stable(end_reg) && $stable(rd_reg))
    else $error("state moved while disabled");
  a_ready_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |-> !acc_ready_o)
    else $error("record accepted while disabled");
  a_take_to_head: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_i && acc_ready_o |=> f_valid)
    else $error("accepted record missing from queue");

  c_read_access: cover property (@(posedge clk_i) f_valid && f_ready && cur.dir_rd);
  c_match: cover property (@(posedge clk_i) match_end_o != '0);
  c_fifo_full: cover property (@(posedge clk_i) ce_i && !acc_ready_o);
  c_frozen: cover property (@(posedge clk_i) !ce_i && acc_valid_i);
  c_bus_write: cover property (@(posedge clk_i) ack_o && $past(we_i));
endmodule
`default_nettype wire

/* rtl/dsp_fifo.sv */
// Parameterised valid/ready FIFO for access records
`default_nettype none
module dsp_fifo #(
  parameter int W = 44,
  parameter int D = 8
) (
  // Clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  // Pointer and count update
  always_comb begin
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    wp_next  = push ? ((wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
    rp_next  = pop ? ((rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else if (ce_i) begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only occupied words are read
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end

  // Ready drops while disabled, else a frozen FIFO would drop the record
  assign in_ready_o  = ce_i && (cnt_reg != (AW + 1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rp_reg];
endmodule
`default_nettype wire

/* rtl/dsp_pkg.sv */
// Package for the DMA access status and pattern match block
`default_nettype none
package dsp_pkg;
  // Register byte offsets
  localparam logic [7:0] DSP_STATUS_OFS  = 8'h00;
  localparam logic [7:0] DSP_ADDR_OFS    = 8'h04;
  localparam logic [7:0] DSP_MODE_OFS    = 8'h08;
  localparam logic [7:0] DSP_PAT_BASE    = 8'h20;
  // Field positions
  localparam int DSP_DIR_BIT = 3;
  localparam int DSP_CH_LSB  = 0;
  localparam int DSP_CH_W    = 3;
  localparam int DSP_PAT_W   = 8;
  // Reset values
  localparam logic [31:0] DSP_ADDR_RST = 32'h0000_0000;
  localparam logic [7:0]  DSP_PAT_RST  = 8'h00;
  // Default channel count and FIFO depth
  localparam int DSP_NCH        = 8;
  localparam int DSP_FIFO_DEPTH = 8;

  // One bus access issued by the engine
  typedef struct packed {
    logic        dir_rd;
    logic [2:0]  chan;
    logic [31:0] addr;
    logic [7:0]  data;
  } dsp_access_t;

  // Bus slave states
  typedef enum logic [0:0] {
    DSP_IDLE = 1'b0,
    DSP_ACK  = 1'b1
  } dsp_bus_state_t;
endpackage
`default_nettype wire
